// ### verilog/camd_cfg.svh
// width, reset, field and encoding constants for the addressing mode decoder
`ifndef CAMD_CFG_SVH
`define CAMD_CFG_SVH
`define CAMD_ADDR_W      16
`define CAMD_DATA_W      8
`define CAMD_RST_PC      16'h0000
// addressing mode codes
`define CAMD_AM_IIX_S    3'h0
`define CAMD_AM_IIX_L    3'h1
`define CAMD_AM_REL_D    3'h2
`define CAMD_AM_REL_I    3'h3
// operation class codes
`define CAMD_OP_OTHER    4'h0
`define CAMD_OP_AND_TST  4'h1
`define CAMD_OP_BTJT     4'h2
`define CAMD_OP_BTJF     4'h3
`define CAMD_OP_IRQ_HI   4'h4
`define CAMD_OP_IRQ_LO   4'h5
`define CAMD_OP_CREL     4'h6
`define CAMD_OP_RCALL    4'h7
`define CAMD_OP_SHORTONL 4'h8
`define CAMD_OP_LONGOK   4'h9
// condition codes for the conditional branch family
`define CAMD_CC_ALWAYS   4'h0
`define CAMD_CC_NEVER    4'h1
`define CAMD_CC_MINUS    4'h2
`define CAMD_CC_PLUS     4'h3
`define CAMD_CC_EQ       4'h4
`define CAMD_CC_NE       4'h5
`define CAMD_CC_C        4'h6
`define CAMD_CC_NC       4'h7
`define CAMD_CC_UGT      4'h8
`define CAMD_CC_ULE      4'h9
`define CAMD_CC_H        4'ha
`define CAMD_CC_NH       4'hb
`endif

// ### verilog/camd_pkg.sv
// types shared by the addressing mode decoder files
package camd_pkg;
    typedef struct packed {
        logic [3:0] op;
        logic [2:0] mode;
        logic [3:0] cond;
        logic [2:0] bit_sel;
        logic       use_y;
    } camd_req_type;

    typedef struct packed {
        logic        neg;
        logic        zero;
        logic        carry;
        logic        half;
    } camd_flags_type;

    typedef struct packed {
        logic [15:0] addr;
        logic        taken;
        logic        illegal;
        logic        n_wr;
        logic        z_wr;
        logic        c_wr;
        logic        n_val;
        logic        z_val;
        logic        c_val;
    } camd_res_type;

    typedef enum logic [2:0] {
        CAMD_IDLE  = 3'b000,
        CAMD_PTRA  = 3'b001,
        CAMD_PTRH  = 3'b010,
        CAMD_PTRL  = 3'b011,
        CAMD_OPND  = 3'b100,
        CAMD_DONE  = 3'b101
    } camd_state_type;
endpackage : camd_pkg

// ### verilog/camd_sync.sv
// two flip-flop synchroniser for the external interrupt pin
`timescale 1ns/10ps
`include "camd_cfg.svh"
module camd_sync
    import camd_pkg::*;
(
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    input  wire logic i_async,
    output logic      o_sync
);
    typedef struct packed {
        logic meta_r;
        logic sync_r;
    } camd_sync_st_type;

    camd_sync_st_type st_r;
    camd_sync_st_type st_nxt;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.meta_r = i_async;
        st_nxt.sync_r = st_r.meta_r;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_sync = st_r.sync_r;
endmodule : camd_sync

// ### verilog/camd_cond.sv
// condition evaluation for conditional relative branches
`timescale 1ns/10ps
`include "camd_cfg.svh"
module camd_cond
    import camd_pkg::*;
(
    input  wire logic           i_sys_clk,
    input  wire logic           i_rst,
    input  wire logic [3:0]     i_cond,
    input  camd_flags_type      i_flags,
    output logic                o_true
);
    typedef struct packed {
        logic unused_r;
    } camd_cond_st_type;

    always_comb begin
        case (i_cond)
            `CAMD_CC_ALWAYS: o_true = 1'b1;
            `CAMD_CC_NEVER:  o_true = 1'b0;
            `CAMD_CC_MINUS:  o_true = i_flags.neg;
            `CAMD_CC_PLUS:   o_true = ~i_flags.neg;
            `CAMD_CC_EQ:     o_true = i_flags.zero;
            `CAMD_CC_NE:     o_true = ~i_flags.zero;
            `CAMD_CC_C:      o_true = i_flags.carry;
            `CAMD_CC_NC:     o_true = ~i_flags.carry;
            `CAMD_CC_UGT:    o_true = ~(i_flags.carry | i_flags.zero);
            `CAMD_CC_ULE:    o_true = i_flags.carry | i_flags.zero;
            `CAMD_CC_H:      o_true = i_flags.half;
            `CAMD_CC_NH:     o_true = ~i_flags.half;
            default:         o_true = 1'b0;
        endcase
    end
endmodule : camd_cond

// ### verilog/camd_top.sv
// addressing mode and branch decode sequencer of the 8-bit core
`timescale 1ns/10ps
`include "camd_cfg.svh"
// What this block does
// RULE1: operand address is unsigned sum of index register and fetched pointer
// RULE2: short form reads one pointer byte via byte address, range 00-1FE
// RULE3: long form reads a 16-bit pointer via byte address, 64K space
// RULE4: relative target is PC plus sign-extended 8-bit offset
// RULE5: relative direct takes offset from byte after opcode
// RULE6: relative indirect reads address after opcode then fetches offset
// RULE7: long pointer form refused for short-only operation classes
// RULE8: and-test ANDs accumulator with operand, updates only N and Z
// RULE9: bit test-and-jump tests one bit, branches true/false, sets carry
// RULE10: irq pin branches test pin level high or low
// RULE11: long effective address is 16 bits, carry out dropped
module camd_top
    import camd_pkg::*;
(
    input  wire logic               i_sys_clk,
    input  wire logic               i_rst,
    input  wire logic               i_start,
    input  camd_req_type            i_req,
    input  wire logic [15:0]        i_pc,
    input  wire logic [7:0]         i_acc,
    input  wire logic [7:0]         i_idx_x,
    input  wire logic [7:0]         i_idx_y,
    input  camd_flags_type          i_flags,
    input  wire logic [7:0]         i_next_byte,
    input  wire logic               i_irq_pin,
    input  wire logic [7:0]         i_mem_rdata,
    input  wire logic               i_mem_rvalid,
    output logic                    o_mem_rd,
    output logic [15:0]             o_mem_addr,
    output logic                    o_busy,
    output logic                    o_done,
    output camd_res_type            o_res
);
    typedef struct packed {
        camd_state_type state;
        camd_req_type   req;
        logic [15:0]    pc;
        logic [7:0]     acc;
        logic [7:0]     idx;
        logic [7:0]     ptr_hi;
        logic           rd_r;
        logic [15:0]    addr_r;
        logic           busy_r;
        logic           done_r;
        camd_res_type   res_r;
    } camd_st_type;

    camd_st_type st_r;
    camd_st_type st_nxt;
    logic        irq_lvl;
    logic        cond_true;
    logic [15:0] rel_tgt;
    logic [7:0]  and_res;
    logic        bit_val;
    logic        short_only;

    camd_sync u_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_async   (i_irq_pin),
        .o_sync    (irq_lvl)
    );

    camd_cond u_cond (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_cond    (st_r.req.cond),
        .i_flags   (i_flags),
        .o_true    (cond_true)
    );

    // ------------------------------------------------------------
    // datapath helpers
    // ------------------------------------------------------------
    assign rel_tgt = st_r.pc + {{8{i_mem_rdata[7]}}, i_mem_rdata}; // RULE4
    assign and_res = st_r.acc & i_mem_rdata; // RULE8
    assign bit_val = i_mem_rdata[st_r.req.bit_sel]; // RULE9
    // and-test takes both pointer forms, like the load and arithmetic class
    assign short_only = (i_req.op != `CAMD_OP_LONGOK)
                        && (i_req.op != `CAMD_OP_AND_TST); // RULE7

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_nxt        = st_r;
        st_nxt.rd_r   = 1'b0;
        st_nxt.done_r = 1'b0;
        case (st_r.state)
            CAMD_IDLE: begin
                if (i_start) begin
                    st_nxt.req    = i_req;
                    st_nxt.pc     = i_pc;
                    st_nxt.acc    = i_acc;
                    st_nxt.idx    = i_req.use_y ? i_idx_y : i_idx_x;
                    st_nxt.res_r  = '0;
                    st_nxt.busy_r = 1'b1;
                    if (i_req.mode == `CAMD_AM_IIX_L && short_only) begin
                        st_nxt.res_r.illegal = 1'b1; // RULE7
                        st_nxt.state  = CAMD_DONE;
                    end else if (i_req.mode == `CAMD_AM_REL_D) begin
                        // offset is the byte following the opcode
                        st_nxt.addr_r = i_pc; // RULE5
                        st_nxt.rd_r   = 1'b1;
                        st_nxt.state  = CAMD_OPND;
                    end else if (i_req.mode == `CAMD_AM_REL_I) begin
                        // byte after opcode addresses the offset
                        st_nxt.addr_r = {8'h00, i_next_byte}; // RULE6
                        st_nxt.rd_r   = 1'b1;
                        st_nxt.state  = CAMD_OPND;
                    end else if (i_req.mode == `CAMD_AM_IIX_L) begin
                        st_nxt.addr_r = {8'h00, i_next_byte}; // RULE3
                        st_nxt.rd_r   = 1'b1;
                        st_nxt.state  = CAMD_PTRH;
                    end else begin
                        st_nxt.addr_r = {8'h00, i_next_byte}; // RULE2
                        st_nxt.rd_r   = 1'b1;
                        st_nxt.state  = CAMD_PTRL;
                    end
                end
            end
            CAMD_PTRH: begin
                if (i_mem_rvalid) begin
                    st_nxt.ptr_hi = i_mem_rdata;
                    st_nxt.addr_r = {8'h00, st_r.addr_r[7:0] + 8'h01};
                    st_nxt.rd_r   = 1'b1;
                    st_nxt.state  = CAMD_PTRA;
                end
            end
            CAMD_PTRA: begin
                if (i_mem_rvalid) begin
                    // carry past bit 15 is dropped
                    st_nxt.addr_r = {st_r.ptr_hi, i_mem_rdata}
                                    + {8'h00, st_r.idx}; // RULE1 RULE11
                    st_nxt.rd_r   = 1'b1;
                    st_nxt.state  = CAMD_OPND;
                end
            end
            CAMD_PTRL: begin
                if (i_mem_rvalid) begin
                    // 9-bit sum reaches at most 1fe
                    st_nxt.addr_r = {8'h00, i_mem_rdata}
                                    + {8'h00, st_r.idx}; // RULE1 RULE2
                    st_nxt.rd_r   = 1'b1;
                    st_nxt.state  = CAMD_OPND;
                end
            end
            CAMD_OPND: begin
                if (i_mem_rvalid) begin
                    st_nxt.res_r.addr = st_r.addr_r;
                    case (st_r.req.op)
                        `CAMD_OP_AND_TST: begin
                            st_nxt.res_r.n_wr  = 1'b1; // RULE8
                            st_nxt.res_r.z_wr  = 1'b1;
                            st_nxt.res_r.n_val = and_res[7];
                            st_nxt.res_r.z_val = (and_res == 8'h00);
                        end
                        `CAMD_OP_BTJT, `CAMD_OP_BTJF: begin
                            st_nxt.res_r.c_wr  = 1'b1; // RULE9
                            st_nxt.res_r.c_val = bit_val;
                            st_nxt.res_r.taken =
                                (st_r.req.op == `CAMD_OP_BTJT)
                                ? bit_val : ~bit_val;
                            st_nxt.res_r.addr  = st_r.pc;
                        end
                        `CAMD_OP_IRQ_HI: begin
                            st_nxt.res_r.taken = irq_lvl; // RULE10
                            st_nxt.res_r.addr  = rel_tgt;
                        end
                        `CAMD_OP_IRQ_LO: begin
                            st_nxt.res_r.taken = ~irq_lvl; // RULE10
                            st_nxt.res_r.addr  = rel_tgt;
                        end
                        `CAMD_OP_CREL: begin
                            st_nxt.res_r.taken = cond_true; // RULE4
                            st_nxt.res_r.addr  = rel_tgt;
                        end
                        `CAMD_OP_RCALL: begin
                            st_nxt.res_r.taken = 1'b1; // RULE4
                            st_nxt.res_r.addr  = rel_tgt;
                        end
                        default: begin
                            st_nxt.res_r.addr = st_r.addr_r;
                        end
                    endcase
                    st_nxt.state = CAMD_DONE;
                end
            end
            CAMD_DONE: begin
                st_nxt.done_r = 1'b1;
                st_nxt.busy_r = 1'b0;
                st_nxt.state  = CAMD_IDLE;
            end
            default: begin
                st_nxt.state = CAMD_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st_r       <= '0;
            st_r.state <= CAMD_IDLE;
            st_r.pc    <= `CAMD_RST_PC;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_mem_rd   = st_r.rd_r;
    assign o_mem_addr = st_r.addr_r;
    assign o_busy     = st_r.busy_r;
    assign o_done     = st_r.done_r;
    assign o_res      = st_r.res_r;
endmodule : camd_top

// ### sim/camd_top_checker.sv
// port checker for the addressing mode decoder
`timescale 1ns/10ps
`include "camd_cfg.svh"
module camd_top_checker
    import camd_pkg::*;
(
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    input wire logic        i_start,
    input camd_req_type     i_req,
    input wire logic [15:0] i_pc,
    input wire logic [7:0]  i_acc,
    input wire logic [7:0]  i_idx_x,
    input wire logic [7:0]  i_idx_y,
    input camd_flags_type   i_flags,
    input wire logic [7:0]  i_next_byte,
    input wire logic        i_irq_pin,
    input wire logic [7:0]  i_mem_rdata,
    input wire logic        i_mem_rvalid,
    input wire logic        o_mem_rd,
    input wire logic [15:0] o_mem_addr,
    input wire logic        o_busy,
    input wire logic        o_done,
    input camd_res_type     o_res
);
    camd_req_type rq_q;
    logic [15:0]  pc_q, tgt;
    logic [7:0]   nb_q, ix_q, acc_q, d0_q, d1_q, last_q;
    logic [1:0]   rd_cnt, rv_cnt;
    assign tgt = pc_q + {{8{last_q[7]}}, last_q};
    // ----------------------------------------
    // capture of the request and returned bytes
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || (i_start && !o_busy)) begin
            rd_cnt <= 2'h0;
            rv_cnt <= 2'h0;
        end else begin
            rd_cnt <= rd_cnt + 2'(o_mem_rd);
            rv_cnt <= rv_cnt + 2'(i_mem_rvalid);
        end
        if (i_start && !o_busy) begin
            rq_q  <= i_req;
            pc_q  <= i_pc;
            nb_q  <= i_next_byte;
            acc_q <= i_acc;
            ix_q  <= i_req.use_y ? i_idx_y : i_idx_x;
        end
        if (i_mem_rvalid) last_q <= i_mem_rdata;
        if (i_mem_rvalid && rv_cnt == 2'h0) d0_q <= i_mem_rdata;
        if (i_mem_rvalid && rv_cnt == 2'h1) d1_q <= i_mem_rdata;
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    chk_ptr_fetch: assert property (
        o_mem_rd && rd_cnt == 2'h0 && rq_q.mode != `CAMD_AM_REL_D
        |-> o_mem_addr == {8'h00, nb_q}) else $error("bad pointer fetch");
    chk_offset_direct: assert property (
        o_mem_rd && rd_cnt == 2'h0 && rq_q.mode == `CAMD_AM_REL_D
        |-> o_mem_addr == pc_q) else $error("bad offset fetch");
    chk_ptr_low: assert property (
        o_mem_rd && rd_cnt == 2'h1 && rq_q.mode == `CAMD_AM_IIX_L
        |-> o_mem_addr == {8'h00, nb_q + 8'h01}) else $error("bad low fetch");
    chk_short_ea: assert property (
        o_mem_rd && rd_cnt == 2'h1 && rq_q.mode == `CAMD_AM_IIX_S
        |-> o_mem_addr == {8'h00, d0_q} + {8'h00, ix_q})
        else $error("bad short address");
    chk_long_ea: assert property (
        o_mem_rd && rd_cnt == 2'h2 && rq_q.mode == `CAMD_AM_IIX_L
        |-> o_mem_addr == {d0_q, d1_q} + {8'h00, ix_q})
        else $error("bad long address");
    chk_long_refused: assert property (
        i_start && !o_busy && i_req.mode == `CAMD_AM_IIX_L
        && i_req.op != `CAMD_OP_LONGOK && i_req.op != `CAMD_OP_AND_TST
        |=> !o_mem_rd ##1 (o_done && o_res.illegal))
        else $error("long form not refused");
    chk_rel_target: assert property (
        o_done && !o_res.illegal && rq_q.mode[1] |-> o_res.addr == tgt)
        else $error("bad relative target");
    chk_and_flags: assert property (
        o_done && rq_q.op == `CAMD_OP_AND_TST |-> !o_res.c_wr && o_res.n_wr
        && o_res.z_wr && o_res.n_val == (acc_q[7] & last_q[7])
        && o_res.z_val == ((acc_q & last_q) == 8'h00))
        else $error("bad and-test flags");
    chk_bit_test: assert property (
        o_done && !o_res.illegal && (rq_q.op == `CAMD_OP_BTJT
        || rq_q.op == `CAMD_OP_BTJF) |-> o_res.c_wr
        && o_res.c_val == last_q[rq_q.bit_sel] && o_res.taken ==
        (last_q[rq_q.bit_sel] ^ (rq_q.op == `CAMD_OP_BTJF)))
        else $error("bad bit test");
    cover property (o_done && o_res.taken);
    cover property (o_done && o_res.illegal);
    cover property (o_mem_rd && rd_cnt == 2'h2);
endmodule : camd_top_checker

// ### sim/camd_mem.sv
// behavioural program and data memory answering the decoder's reads
`timescale 1ns/10ps
module camd_mem (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_addr,
    input  wire logic [3:0]  i_lat,
    output logic [7:0]       o_rdata,
    output logic             o_rvalid
);
    logic [7:0]  mem [0:65535];
    logic [15:0] addr_r;
    logic [3:0]  cnt_r;
    logic        pend_r;
    // outside reset, data line toggles whenever no answer is valid; reset holds it at 00
    always_ff @(posedge i_sys_clk) begin
        o_rvalid <= 1'b0;
        o_rdata  <= ~o_rdata;
        if (i_rst) begin
            pend_r  <= 1'b0;
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            pend_r <= 1'b1;
            addr_r <= i_addr;
            cnt_r  <= i_lat;
        end else if (pend_r && cnt_r == 4'h0) begin
            pend_r   <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata  <= mem[addr_r];
        end else if (pend_r) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule : camd_mem

// ### sim/camd_tb.sv
// self-checking bench for the addressing mode decoder
`timescale 1ns/10ps
`include "camd_cfg.svh"
module testbench;
    import camd_pkg::*;
    logic           i_sys_clk = 1'b0, i_rst = 1'b1, i_start = 1'b0;
    logic           i_irq_pin = 1'b0, i_mem_rvalid, o_mem_rd, o_busy, o_done;
    camd_req_type   i_req = '0;
    camd_flags_type i_flags = '0;
    camd_res_type   o_res;
    logic [15:0]    i_pc = 16'h0000, o_mem_addr;
    logic [7:0]     i_acc = 8'h00, i_idx_x = 8'h00, i_idx_y = 8'h00;
    logic [7:0]     i_next_byte = 8'h00, i_mem_rdata;
    logic [3:0]     lat = 4'h0;
    int             num_errors = 0, num_checks = 0;
    always #25 i_sys_clk = ~i_sys_clk;
    camd_top u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_start(i_start),
        .i_req(i_req), .i_pc(i_pc), .i_acc(i_acc), .i_idx_x(i_idx_x),
        .i_idx_y(i_idx_y), .i_flags(i_flags), .i_next_byte(i_next_byte),
        .i_irq_pin(i_irq_pin), .i_mem_rdata(i_mem_rdata),
        .i_mem_rvalid(i_mem_rvalid), .o_mem_rd(o_mem_rd),
        .o_mem_addr(o_mem_addr), .o_busy(o_busy), .o_done(o_done),
        .o_res(o_res));
    camd_mem u_mem (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_rd(o_mem_rd),
        .i_addr(o_mem_addr), .i_lat(lat), .o_rdata(i_mem_rdata),
        .o_rvalid(i_mem_rvalid));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk16(input string nm, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk16
    task automatic chk1(input string nm, input logic e, g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %b got %b", nm, e, g);
        end
    endtask : chk1
    // y index is always the complement of x so the selection shows
    task automatic run(input logic [3:0] op, input logic [2:0] md,
        input logic [3:0] cc, input logic [2:0] bs, input logic uy,
        input logic [15:0] pc, input logic [7:0] nb, xv, av);
        int n;
        @(posedge i_sys_clk);
        i_req <= '{op, md, cc, bs, uy};
        i_pc <= pc;
        i_next_byte <= nb;
        i_idx_x <= xv;
        i_idx_y <= ~xv;
        i_acc <= av;
        i_start <= 1'b1;
        @(posedge i_sys_clk);
        i_start <= 1'b0;
        #1;
        chk1("busy", 1'b1, o_busy);
        for (n = 0; n < 60 && o_done !== 1'b1; n++) begin
            @(posedge i_sys_clk);
            #1;
        end
        if (o_done !== 1'b1) begin
            chk1("done", 1'b1, o_done);
            stop_test();
        end
        chk1("busy idle", 1'b0, o_busy);
    endtask : run
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_short;
        u_mem.mem[16'h0040] = 8'hff;
        u_mem.mem[16'h01fe] = 8'h0f;
        u_mem.mem[16'h0041] = 8'h10;
        u_mem.mem[16'h0011] = 8'hc1;
        run(`CAMD_OP_AND_TST, `CAMD_AM_IIX_S, 4'h0, 3'h0, 1'b0,
            16'h1234, 8'h40, 8'hff, 8'hf0);
        chk16("short ea", 16'h01fe, o_res.addr);
        chk1("zero", 1'b1, o_res.z_val);
        run(`CAMD_OP_AND_TST, `CAMD_AM_IIX_S, 4'h0, 3'h0, 1'b1,
            16'h1234, 8'h41, 8'hfe, 8'h80);
        chk16("y ea", 16'h0011, o_res.addr);
        chk1("neg", 1'b1, o_res.n_val);
        chk1("carry wr", 1'b0, o_res.c_wr);
    endtask : t_short
    task automatic t_long;
        u_mem.mem[16'h00ff] = 8'hff;
        u_mem.mem[16'h0000] = 8'hfe;
        u_mem.mem[16'h0001] = 8'h5a;
        lat <= 4'h3;
        run(`CAMD_OP_LONGOK, `CAMD_AM_IIX_L, 4'h0, 3'h0, 1'b1,
            16'h2000, 8'hff, 8'hfc, 8'h00);
        lat <= 4'h0;
        chk16("long ea", 16'h0001, o_res.addr);
        chk1("long ok", 1'b0, o_res.illegal);
        run(`CAMD_OP_AND_TST, `CAMD_AM_IIX_L, 4'h0, 3'h0, 1'b1,
            16'h2000, 8'hff, 8'hfc, 8'ha5);
        chk1("long and ok", 1'b0, o_res.illegal);
        chk16("long and ea", 16'h0001, o_res.addr);
        chk1("long and zero", 1'b1, o_res.z_val);
    endtask : t_long
    task automatic t_refuse;
        logic [3:0] ops [3] = '{`CAMD_OP_SHORTONL, `CAMD_OP_BTJT,
                                `CAMD_OP_BTJF};
        foreach (ops[i]) begin
            run(ops[i], `CAMD_AM_IIX_L, 4'h0, 3'h0, 1'b0,
                16'h2000, 8'h40, 8'h00, 8'h00);
            chk1("illegal", 1'b1, o_res.illegal);
        end
    endtask : t_refuse
    task automatic t_bits;
        logic c;
        u_mem.mem[16'h0020] = 8'h30;
        u_mem.mem[16'h0030] = 8'h80;
        for (int i = 0; i < 4; i++) begin
            run(i[0] ? `CAMD_OP_BTJF : `CAMD_OP_BTJT, `CAMD_AM_IIX_S,
                4'h0, i[1] ? 3'h7 : 3'h0, 1'b0, 16'h3000, 8'h20, 8'h00,
                8'h00);
            c = i[1];
            chk1("bit carry", c, o_res.c_val);
            chk1("bit taken", c ^ i[0], o_res.taken);
        end
    endtask : t_bits
    task automatic t_rel;
        logic [11:0] tk = 12'ha65;
        u_mem.mem[16'h0100] = 8'h80;
        u_mem.mem[16'h0077] = 8'h7f;
        i_flags <= '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int c = 0; c < 12; c++) begin
            run(`CAMD_OP_CREL, `CAMD_AM_REL_D, 4'(c), 3'h0, 1'b0,
                16'h0100, 8'h00, 8'h00, 8'h00);
            chk16("rel target", 16'h0080, o_res.addr);
            chk1("cond taken", tk[c], o_res.taken);
        end
        run(`CAMD_OP_RCALL, `CAMD_AM_REL_I, 4'h0, 3'h0, 1'b0,
            16'hfff0, 8'h77, 8'h00, 8'h00);
        chk16("indirect target", 16'h006f, o_res.addr);
    endtask : t_rel
    task automatic t_irq;
        for (int i = 0; i < 4; i++) begin
            i_irq_pin <= i[1];
            repeat (4) @(posedge i_sys_clk);
            run(i[0] ? `CAMD_OP_IRQ_LO : `CAMD_OP_IRQ_HI, `CAMD_AM_REL_D,
                4'h0, 3'h0, 1'b0, 16'h0100, 8'h00, 8'h00, 8'h00);
            chk1("irq taken", i[1] ^ i[0], o_res.taken);
        end
    endtask : t_irq
    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        t_short();
        t_long();
        t_refuse();
        t_bits();
        t_rel();
        t_irq();
        stop_test();
    end
endmodule : testbench
bind camd_top camd_top_checker u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_start(i_start), .i_req(i_req), .i_pc(i_pc), .i_acc(i_acc),
    .i_idx_x(i_idx_x), .i_idx_y(i_idx_y), .i_flags(i_flags),
    .i_next_byte(i_next_byte), .i_irq_pin(i_irq_pin),
    .i_mem_rdata(i_mem_rdata), .i_mem_rvalid(i_mem_rvalid),
    .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr), .o_busy(o_busy),
    .o_done(o_done), .o_res(o_res));
